// ### pkg/sep_bus_if.sv
// Two-wire bus joining the memory end and the master end.
// Assumes open-drain lines; the level is low when any party enables its driver.
`timescale 1ns/1ps
interface sep_bus_if;
    logic scl_o;
    logic scl_oe;
    logic sda_dev_o;
    logic sda_dev_oe;
    logic sda_mst_o;
    logic sda_mst_oe;
    logic scl;
    logic sda;

    // Wired-and of the open-drain drivers
    assign scl = ~(scl_oe & ~scl_o);
    assign sda = ~((sda_dev_oe & ~sda_dev_o) | (sda_mst_oe & ~sda_mst_o));

    modport device (input scl, input sda, output sda_dev_o, output sda_dev_oe);
    modport master (input scl, input sda, output scl_o, output scl_oe,
                    output sda_mst_o, output sda_mst_oe);
endinterface

// ### pkg/sep_defs.svh
// Constants shared by both ends of the two-wire serial read path.
// Assumes inclusion by bare name; definitions only.
`ifndef SEP_DEFS_SVH
`define SEP_DEFS_SVH
`define SEP_ADDR_W        11
`define SEP_BLK_W         3
`define SEP_MEM_RESET     8'hff
`define SEP_DEV_TYPE      4'h5 // Arbitrary type code of our own making
`define SEP_RW_BIT        0
`define SEP_CLK_PERIOD_NS 100
`define SEP_SCL_PERIOD_NS 800
`define SEP_SCL_HALF      ((`SEP_SCL_PERIOD_NS / 2) / `SEP_CLK_PERIOD_NS)
`endif

// ### pkg/sep_pkg.sv
// Types used by the master end of the two-wire serial read path and by its bench.
// Assumes sep_defs.svh is compiled alongside.
package sep_pkg;
    typedef enum logic [1:0] {
        SEP_OP_CUR,
        SEP_OP_RAND
    } sep_op_t;
endpackage

// ### rtl/sep_device.sv
// Memory end: two-wire slave serving current, random and sequential reads.
// Assumes a master keeping the protocol; bus lines sampled on ref_clk.
// A write select only loads the counter; data bytes of a write are not served.
//
// What this block does
// - Reads behave alike whatever the mode pin.
// - Every byte reads all ones initially.
// - Address counter advances after each output byte.
// - Read select acked, then counter byte sent.
// - Master ends single read: no ack, stop.
// - Dummy write loads address, restart, then read.
// - Master repeats the same upper seven select bits.
// - Acked byte leads to next consecutive byte.
// - Master ends sequence: withhold ack, stop.
// - Counter wraps from top to lowest address.
// - No ack in ninth bit means standby.
// - Select byte: type, block bits, read/write bit.
// - Stop returns device to standby.
`timescale 1ns/1ps
`include "sep_defs.svh"

module sep_device #(
    parameter int ADDR_W = `SEP_ADDR_W
) (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    // Bus
    sep_bus_if.device bus,
    // Mode pin, has no effect on reads
    input  wire logic multibyte_mode,
    // Status
    output logic      busy,
    output logic [ADDR_W-1:0] addr_now
);
    // Frame states; the ack states cover the ninth bit of each byte
    typedef enum logic [2:0] {
        ST_IDLE, ST_SEL, ST_SEL_ACK, ST_ADDR, ST_ADDR_ACK, ST_TX, ST_TX_ACK
    } sep_dev_st_t;

    localparam int DEPTH = 1 << ADDR_W;

    // Type field match of a select byte
    function automatic logic sep_type_hit(input logic [7:0] b);
        return b[7:4] == `SEP_DEV_TYPE;
    endfunction

    // Driver enable for the first bit of an outgoing byte: pull low for a zero
    function automatic logic sep_pull_low(input logic [7:0] b);
        return ~b[7];
    endfunction

    // Storage and frame state
    logic [7:0]        mem [DEPTH];
    sep_dev_st_t       st_q;
    logic [3:0]        bit_q;
    logic [7:0]        sh_q;
    logic [ADDR_W-1:0] addr_q;
    logic [`SEP_BLK_W-1:0] blk_q;
    logic              sda_oe_q;
    // Synchronised line levels and their edges
    logic              scl_lvl;
    logic              scl_rise;
    logic              scl_fall;
    logic              sda_lvl;
    logic              sda_rise;
    logic              sda_fall;
    logic              start_c;
    logic              stop_c;
    logic              unused_mode;

    // Both lines share the same lag, so start and stop stay recognisable
    sep_sync u_scl (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .line_in (bus.scl),
        .level   (scl_lvl),
        .rise    (scl_rise),
        .fall    (scl_fall)
    );

    sep_sync u_sda (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .line_in (bus.sda),
        .level   (sda_lvl),
        .rise    (sda_rise),
        .fall    (sda_fall)
    );

    // Bus conditions: sda moving while scl is high
    assign start_c = sda_fall & scl_lvl;
    assign stop_c  = sda_rise & scl_lvl;
    assign unused_mode = multibyte_mode;

    // Memory starts erased; writes are outside this block
    initial begin
        for (int i = 0; i < DEPTH; i++) begin
            mem[i] = `SEP_MEM_RESET;
        end
    end

    // Bus state machine, counter and shifter in one process to keep timing exact
    // Stop and start outrank the frame state, so a cut frame always ends cleanly
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q     <= ST_IDLE;
            bit_q    <= 4'h0;
            sh_q     <= 8'h00;
            addr_q   <= '0;
            blk_q    <= '0;
            sda_oe_q <= 1'b0;
        end else if (stop_c) begin
            st_q     <= ST_IDLE;
            sda_oe_q <= 1'b0;
        end else if (start_c) begin
            st_q     <= ST_SEL;
            bit_q    <= 4'h0;
            sda_oe_q <= 1'b0;
        end else begin
            case (st_q)
                // Standby: line released until a start
                ST_IDLE: begin
                    sda_oe_q <= 1'b0;
                end

                // Shift in a select or address byte on rising scl
                ST_SEL, ST_ADDR: begin
                    if (scl_rise) begin
                        sh_q  <= {sh_q[6:0], sda_lvl};
                        bit_q <= bit_q + 4'h1;
                    end else if (scl_fall && bit_q == 4'h8) begin
                        bit_q <= 4'h0;
                        if (st_q == ST_ADDR) begin
                            // Dummy write loads the whole counter: select block bits above the address byte
                            addr_q   <= {blk_q, sh_q};
                            sda_oe_q <= 1'b1;
                            st_q     <= ST_ADDR_ACK;
                        end else if (sep_type_hit(sh_q)) begin
                            blk_q    <= sh_q[3:1];
                            sda_oe_q <= 1'b1;
                            st_q     <= ST_SEL_ACK;
                        end else begin
                            st_q <= ST_IDLE; // Not addressed: stay silent
                        end
                    end
                end

                // Hold the ack low through the ninth clock
                ST_SEL_ACK, ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        if (st_q == ST_SEL_ACK && sh_q[`SEP_RW_BIT]) begin
                            // Read: first data bit goes out as the ack is released
                            sh_q     <= mem[addr_q];
                            sda_oe_q <= sep_pull_low(mem[addr_q]);
                            st_q     <= ST_TX;
                        end else begin
                            sda_oe_q <= 1'b0;
                            st_q     <= (st_q == ST_SEL_ACK) ? ST_ADDR : ST_IDLE;
                        end
                    end
                end

                // Data bits change only after scl has fallen
                ST_TX: begin
                    if (scl_fall) begin
                        bit_q <= bit_q + 4'h1;
                        if (bit_q == 4'h7) begin
                            // Release for the master's ack, then move on
                            sda_oe_q <= 1'b0;
                            // Roll-over is free: the sum simply drops its carry
                            addr_q   <= addr_q + 1'b1;
                            bit_q    <= 4'h0;
                            st_q     <= ST_TX_ACK;
                        end else begin
                            sh_q     <= {sh_q[6:0], 1'b0};
                            sda_oe_q <= ~sh_q[6];
                        end
                    end
                end

                // Master's ack decides between next byte and standby
                ST_TX_ACK: begin
                    if (scl_rise) begin
                        if (sda_lvl) begin
                            st_q <= ST_IDLE;
                        end else begin
                            sh_q <= mem[addr_q];
                        end
                    end else if (scl_fall) begin
                        sda_oe_q <= sep_pull_low(sh_q);
                        st_q     <= ST_TX;
                    end
                end

                // Unused codes fall back to standby
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Open drain: only ever pull low, the pull-up gives the high level
    assign bus.sda_dev_o  = 1'b0;
    assign bus.sda_dev_oe = sda_oe_q;
    // Status: busy means inside a frame
    assign busy           = (st_q != ST_IDLE);
    assign addr_now       = addr_q;
endmodule

// ### rtl/sep_master.sv
// Master end: issues current or random reads of 1 to 255 bytes (a length of 0 reads one byte).
// Assumes a device answering on the shared bus; drives scl from a divider.
`timescale 1ns/1ps
`include "sep_defs.svh"

module sep_master #(
    parameter int HALF = `SEP_SCL_HALF
) (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    // Bus
    sep_bus_if.master bus,
    // Request
    input  wire logic         req_valid,
    output logic              req_ready,
    input  wire sep_pkg::sep_op_t req_op,
    input  wire logic [2:0]   req_blk,
    input  wire logic [7:0]   req_addr,
    input  wire logic [7:0]   req_len,
    // Answer
    output logic              rd_valid,
    output logic [7:0]        rd_data,
    output logic              done,
    output logic              nack
);
    typedef enum logic [2:0] {
        M_IDLE, M_START, M_BYTE, M_STOP
    } sep_mst_st_t;

    sep_mst_st_t st_q;
    logic [7:0]  cnt_q;
    logic [1:0]  ph_q;
    logic [3:0]  bit_q;
    logic [7:0]  sh_q;
    logic [1:0]  stage_q;
    logic [7:0]  left_q;
    logic        rand_q;
    logic [2:0]  blk_q;
    logic [7:0]  adr_q;
    logic        scl_q;
    logic        sda_q;
    logic        tick;
    logic        sda_s;

    sep_sync u_sda (.ref_clk(ref_clk), .sys_rst(sys_rst), .line_in(bus.sda),
                    .level(sda_s), .rise(), .fall());

    assign tick      = (cnt_q == 8'(HALF - 1));
    assign req_ready = (st_q == M_IDLE);

    // Quarter-phase ticker; each bit uses four ticks
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= tick ? 8'h00 : cnt_q + 8'h01;
        end
    end

    // Sequencer: stage 0 select, 1 address, 2 reselect read, 3 data
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q     <= M_IDLE;
            ph_q     <= 2'h0;
            bit_q    <= 4'h0;
            sh_q     <= 8'h00;
            stage_q  <= 2'h0;
            left_q   <= 8'h00;
            rand_q   <= 1'b0;
            blk_q    <= 3'h0;
            adr_q    <= 8'h00;
            scl_q    <= 1'b1;
            sda_q    <= 1'b1;
            rd_valid <= 1'b0;
            rd_data  <= 8'h00;
            done     <= 1'b0;
            nack     <= 1'b0;
        end else begin
            rd_valid <= 1'b0;
            done     <= 1'b0;
            case (st_q)
                M_IDLE: begin
                    scl_q <= 1'b1;
                    sda_q <= 1'b1;
                    if (req_valid) begin
                        rand_q  <= (req_op == sep_pkg::SEP_OP_RAND);
                        blk_q   <= req_blk; // Same block bits both selects
                        adr_q   <= req_addr;
                        left_q  <= (req_len == 8'h00) ? 8'h01 : req_len;
                        stage_q <= (req_op == sep_pkg::SEP_OP_RAND) ? 2'h0 : 2'h2;
                        nack    <= 1'b0;
                        ph_q    <= 2'h0;
                        st_q    <= M_START;
                    end
                end
                M_START: if (tick) begin
                    ph_q <= ph_q + 2'h1;
                    case (ph_q)
                        2'h0: begin
                            scl_q <= 1'b1;
                            sda_q <= 1'b1;
                        end
                        2'h1: sda_q <= 1'b0;
                        2'h2: scl_q <= 1'b0;
                        default: begin
                            sh_q  <= {`SEP_DEV_TYPE, blk_q, stage_q == 2'h2};
                            bit_q <= 4'h0;
                            st_q  <= M_BYTE;
                        end
                    endcase
                end
                M_BYTE: if (tick) begin
                    ph_q <= ph_q + 2'h1;
                    case (ph_q)
                        2'h0: begin
                            // Set data while clock low
                            if (bit_q == 4'h8) begin
                                sda_q <= (stage_q == 2'h3) ? (left_q == 8'h01) : 1'b1;
                            end else begin
                                sda_q <= (stage_q == 2'h3) ? 1'b1 : sh_q[7];
                            end
                        end
                        2'h1: scl_q <= 1'b1;
                        2'h2: begin
                            if (bit_q == 4'h8) begin
                                if (stage_q != 2'h3 && sda_s) begin
                                    nack <= 1'b1;
                                end
                            end else begin
                                sh_q <= {sh_q[6:0], sda_s};
                            end
                        end
                        default: begin
                            scl_q <= 1'b0;
                            bit_q <= bit_q + 4'h1;
                            if (bit_q == 4'h7 && stage_q == 2'h3) begin
                                rd_data  <= sh_q;
                                rd_valid <= 1'b1;
                            end
                            if (bit_q == 4'h8) begin
                                bit_q <= 4'h0;
                                if (nack || (stage_q == 2'h3 && left_q == 8'h01)) begin
                                    st_q <= M_STOP;
                                end else if (stage_q == 2'h0) begin
                                    stage_q <= 2'h1;
                                    sh_q    <= adr_q;
                                end else if (stage_q == 2'h1) begin
                                    stage_q <= 2'h2;
                                    st_q    <= M_START;
                                end else if (stage_q == 2'h2) begin
                                    stage_q <= 2'h3;
                                end else begin
                                    left_q <= left_q - 8'h01;
                                end
                            end
                        end
                    endcase
                end
                M_STOP: if (tick) begin
                    ph_q <= ph_q + 2'h1;
                    case (ph_q)
                        2'h0: sda_q <= 1'b0;
                        2'h1: scl_q <= 1'b1;
                        2'h2: sda_q <= 1'b1;
                        default: begin
                            done <= 1'b1;
                            st_q <= M_IDLE;
                        end
                    endcase
                end
                default: st_q <= M_IDLE;
            endcase
        end
    end

    assign bus.scl_o      = 1'b0;
    assign bus.scl_oe     = ~scl_q;
    assign bus.sda_mst_o  = 1'b0;
    assign bus.sda_mst_oe = ~sda_q;
endmodule

// ### rtl/sep_sync.sv
// Two-flop synchroniser with edge detection for bus lines.
// Assumes asynchronous inputs; the first flop feeds only the second.
`timescale 1ns/1ps
module sep_sync (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    // Line
    input  wire logic line_in,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic meta_q;
    logic sync_q;
    logic last_q;

    // Lines idle high, so reset to one to avoid a false edge
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
            last_q <= 1'b1;
        end else begin
            meta_q <= line_in;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    assign level = sync_q;
    assign rise  = sync_q & ~last_q;
    assign fall  = ~sync_q & last_q;
endmodule

// ### tb/sep_bus_assertions.sv
// Concurrent checks on the two-wire bus between the memory and master ends.
// Assumes every line is sampled on ref_clk and a quarter bit of four cycles.
`timescale 1ns/1ps
module sep_bus_assertions (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Open-drain drivers
    input wire logic scl_o,
    input wire logic scl_oe,
    input wire logic sda_dev_o,
    input wire logic sda_dev_oe,
    input wire logic sda_mst_o,
    input wire logic sda_mst_oe,
    // Resolved lines
    input wire logic scl,
    input wire logic sda
);
    logic       scl_q;
    logic       sda_q;
    logic [3:0] pos_q;
    logic       sel_q;
    logic       start;
    logic       rise;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    // Line history; released lines read high during reset
    assign start = scl & scl_q & sda_q & ~sda;
    assign rise  = scl & ~scl_q;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
        end
    end

    // Bit slot within a nine-bit frame, restarted by every start
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pos_q <= 4'h0;
        end else if (start) begin
            pos_q <= 4'h0;
        end else if (rise) begin
            pos_q <= (pos_q == 4'h8) ? 4'h0 : pos_q + 4'h1;
        end
    end

    // High from a start until the select byte has been acknowledged
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sel_q <= 1'b0;
        end else if (start) begin
            sel_q <= 1'b1;
        end else if (rise && pos_q == 4'h8) begin
            sel_q <= 1'b0;
        end
    end

    sequence s_start;
        scl && $past(scl) && $fell(sda);
    endsequence
    sequence s_stop;
        scl && $past(scl) && $rose(sda);
    endsequence
    sequence s_ack_slot;
        rise && pos_q == 4'h8;
    endsequence

    a_start_order: assert property (s_start |-> ##[1:12] !scl)
        else $error("scl not pulled low after start");
    a_stop_quiet: assert property (s_stop |-> !sda_dev_oe [*8])
        else $error("memory drives sda after stop");
    a_noack_standby: assert property (s_ack_slot ##0 sda |-> !sda_dev_oe [*8])
        else $error("memory drives sda after missing acknowledge");
    a_select_acked: assert property (s_ack_slot ##0 sel_q |-> !sda)
        else $error("select byte not acknowledged");
    a_dev_change_low: assert property ($changed(sda_dev_oe) |-> !scl)
        else $error("memory changed sda while scl high");
    a_scl_low_min: assert property ($rose(scl_oe) |-> scl_oe [*4])
        else $error("scl low phase too short");
    a_scl_high_min: assert property ($fell(scl_oe) |-> !scl_oe [*4])
        else $error("scl high phase too short");
    a_drive_zero: assert property ((scl_oe | sda_dev_oe | sda_mst_oe)
        |-> !(scl_o | sda_dev_o | sda_mst_o))
        else $error("open-drain driver not driving low");
endmodule

// ### tb/serial_eeprom_read_path_test.sv
// Self-checking bench: master end and memory end joined on one bus.
// Assumes the memory starts all ones and scl comes from the master divider.
`timescale 1ns/1ps
`include "sep_defs.svh"
module serial_eeprom_read_path_test;
    logic             ref_clk   = 1'b0;
    logic             sys_rst   = 1'b1;
    logic             req_valid = 1'b0;
    logic             mode      = 1'b0;
    logic             req_ready, rd_valid, done, nack, busy;
    sep_pkg::sep_op_t req_op    = sep_pkg::SEP_OP_CUR;
    logic [2:0]       req_blk   = 3'h0;
    logic [7:0]       req_addr  = 8'h00;
    logic [7:0]       req_len   = 8'h01;
    logic [7:0]       rd_data;
    logic [7:0]       sel       = 8'h00;
    logic [10:0]      addr_now;
    logic [10:0]      ptr       = 11'h000;
    logic [10:0]      q[$];
    logic [31:0]      rnd       = 32'h1;
    int               n_errors  = 0, num_checks = 0, cyc = 0, nbit = 0, n_start = 0;

    sep_bus_if bus ();
    sep_device i_sep_device (.ref_clk(ref_clk), .sys_rst(sys_rst), .bus(bus.device),
        .multibyte_mode(mode), .busy(busy), .addr_now(addr_now));
    sep_master i_sep_master (.ref_clk(ref_clk), .sys_rst(sys_rst), .bus(bus.master),
        .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op), .req_blk(req_blk),
        .req_addr(req_addr), .req_len(req_len), .rd_valid(rd_valid), .rd_data(rd_data),
        .done(done), .nack(nack));
    sep_bus_assertions i_sep_bus_assertions (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .scl_o(bus.scl_o), .scl_oe(bus.scl_oe), .sda_dev_o(bus.sda_dev_o),
        .sda_dev_oe(bus.sda_dev_oe), .sda_mst_o(bus.sda_mst_o),
        .sda_mst_oe(bus.sda_mst_oe), .scl(bus.scl), .sda(bus.sda));

    always #50 ref_clk = ~ref_clk;

    function logic [31:0] nxt();
        rnd = rnd ^ (rnd << 13);
        rnd = rnd ^ (rnd >> 17);
        rnd = rnd ^ (rnd << 5);
        return rnd;
    endfunction

    task check(input logic [10:0] seen, input logic [10:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task complete_run();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // One read transaction; the expected bytes and final counter go on the queue
    task rd(input sep_pkg::sep_op_t op, input logic [2:0] blk, input logic [7:0] a,
            input logic [7:0] n);
        int k;
        @(negedge ref_clk);
        void'(nxt());
        mode = rnd[4];
        req_op = op;
        req_blk = (op == sep_pkg::SEP_OP_CUR) ? ptr[10:8] : blk;
        req_addr = a;
        req_len = n;
        check({10'h0, req_ready}, 11'h1);
        req_valid = 1'b1;
        if (op == sep_pkg::SEP_OP_RAND) ptr = {blk, a};
        for (k = 0; k < ((n == 8'h0) ? 1 : n); k++) q.push_back(11'h0ff);
        ptr = ptr + ((n == 8'h0) ? 11'h1 : {3'h0, n});
        q.push_back(ptr);
        @(negedge ref_clk);
        req_valid = 1'b0;
        for (k = 0; k < 3000 && done !== 1'b1; k++) @(negedge ref_clk);
        check(11'(n_start), (op == sep_pkg::SEP_OP_RAND) ? 11'h2 : 11'h1);
        n_start = 0;
        check({9'h0, bus.scl, bus.sda}, 11'h3);
        for (k = 0; k < 8 && busy !== 1'b0; k++) @(negedge ref_clk);
        check({10'h0, busy}, 11'h0);
        $display("test end: op %0d blk %h addr %h len %0d", op, blk, a, n);
    endtask

    // Results are compared in order against the notes left by the driver
    always @(negedge ref_clk) begin
        if (rd_valid === 1'b1) check({3'h0, rd_data}, q.pop_front());
        if (done === 1'b1) begin
            check(addr_now, q.pop_front());
            check({10'h0, nack}, 11'h0);
        end
    end

    // Start conditions restart the bit count of the select byte
    always @(negedge bus.sda) begin
        if (bus.scl === 1'b1) begin
            nbit = 0;
            n_start++;
        end
    end

    // Select byte on the wire: type, block bits, read flag, most significant first
    always @(posedge bus.scl) begin
        sel = {sel[6:0], bus.sda};
        nbit++;
        if (nbit == 8) check({3'h0, sel}, {3'h0, `SEP_DEV_TYPE, req_blk,
            (req_op == sep_pkg::SEP_OP_CUR || n_start == 2)});
    end

    // Hang guard: well above the few thousand cycles the reads need
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc >= 40000) begin
            n_errors++;
            complete_run();
        end
    end

    initial begin
        logic [31:0] r;
        repeat (8) @(negedge ref_clk);
        sys_rst = 1'b0;
        rd(sep_pkg::SEP_OP_CUR, 3'h0, 8'h00, 8'h01);
        rd(sep_pkg::SEP_OP_RAND, 3'h2, 8'h34, 8'h01);
        rd(sep_pkg::SEP_OP_CUR, 3'h0, 8'h00, 8'h04);
        rd(sep_pkg::SEP_OP_RAND, 3'h3, 8'hfe, 8'h03);
        rd(sep_pkg::SEP_OP_RAND, 3'h7, 8'hfe, 8'h04);
        rd(sep_pkg::SEP_OP_CUR, 3'h0, 8'h00, 8'h00);
        for (int i = 0; i < 6; i++) begin
            r = nxt();
            rd(sep_pkg::sep_op_t'({1'b0, r[0]}), r[3:1], r[15:8], {6'h0, r[17:16]} + 8'h1);
        end
        complete_run();
    end
endmodule
